// >>> sfe_pkg.sv
package sfe_pkg;
    // Opcodes
    localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OP_RDSR = 8'h05;
    localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
    localparam logic [7:0] OP_HALF_BLOCK = 8'h52;
    localparam logic [7:0] OP_FULL_BLOCK = 8'hd8;
    localparam logic [7:0] OP_CE1 = 8'h60;
    localparam logic [7:0] OP_CE2 = 8'hc7;
    localparam logic [7:0] OP_MAKER_DEVICE_ID = 8'h90;
    localparam logic [7:0] OP_IDENT_READ = 8'h9f;
    localparam logic [7:0] OP_UID = 8'h4b;
    localparam logic [7:0] OP_ERSEC = 8'h44;
    // Bit counts on the link
    localparam logic [7:0] BITS_OP = 8'h08;
    localparam logic [7:0] BITS_ADDR = 8'h20;
    localparam logic [7:0] BITS_DUMMY = 8'h28;
    localparam logic [7:0] BITS_ID2 = 8'h10;
    localparam logic [7:0] BITS_ID3 = 8'h18;
    localparam logic [7:0] BITS_UID = 8'h80;
    // Status byte fields
    localparam int BUSY_BIT = 0;
    localparam int LATCH_BIT = 1;
    localparam int BP_LSB = 2;
    localparam int LOCK_BIT = 6;
    localparam int COMPLEMENT_BIT = 7;
    // Protect field values
    localparam logic [2:0] BP_NONE = 3'h0;
    localparam logic [1:0] BP_UPPER_ALL = 2'h3;
    // Security register address match: A23..A9 zero
    localparam logic [23:0] SEC_ADDR_MASK = 24'hfffe00;
    localparam logic [23:0] ADDR_ZERO = 24'h000000;
    // Region sizes, as address bit counts
    localparam int SECTOR_BITS = 12;
    localparam int HALF_BITS = 15;
    localparam int FULL_BITS = 16;
    localparam int ARRAY_BITS = 19;
    // Identification values, arbitrary
    localparam logic [7:0] MAKER_ID = 8'h5a;
    localparam logic [7:0] DEVICE_ID = 8'h12;
    localparam logic [7:0] MEM_TYPE = 8'h60;
    localparam logic [7:0] CAPACITY = 8'h13;
    localparam logic [127:0] UNIQUE_ID = 128'h0123456789abcdef_fedcba9876543210;
    // Erase durations in microseconds and cycles at 200 MHz
    localparam int CLK_MHZ = 200;
    localparam int SECTOR_US = 100;
    localparam int HALF_US = 200;
    localparam int FULL_US = 300;
    localparam int CE_US = 1000;
    localparam int SECTOR_CYC = SECTOR_US * CLK_MHZ;
    localparam int HALF_CYC = HALF_US * CLK_MHZ;
    localparam int FULL_CYC = FULL_US * CLK_MHZ;
    localparam int CE_CYC = CE_US * CLK_MHZ;
    // Host link clock half period minus one, in system cycles
    localparam logic [7:0] HALF_PERIOD = 8'h0c;
    // Host command kinds
    typedef enum logic [2:0] {
        SFE_CMD_WRITE_ENABLE = 3'b000,
        SFE_CMD_ERASE = 3'b001,
        SFE_CMD_CHIP = 3'b010,
        SFE_CMD_READ = 3'b011,
        SFE_CMD_RDSR = 3'b100
    } sfe_cmd_e;
endpackage : sfe_pkg

// >>> sfe_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sfe_link_if;
    logic cs_n;
    logic sclk;
    logic si;
    logic so;
    logic so_oe;
    modport host (output cs_n, output sclk, output si, input so);
    modport flash (input cs_n, input sclk, input si, output so, output so_oe);
endinterface : sfe_link_if
`default_nettype wire

// >>> sfe_sync.sv
`timescale 1ns/1ps
`default_nettype none
// Two-flop synchroniser for one level
module sfe_sync #(
    // Level shown in reset; match the pin's idle level to avoid a false edge
    parameter logic RST_VAL = 1'b0
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Level in and out
    input wire logic din,
    output logic dout
);
    logic meta;
    // First flop feeds only the second
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            meta <= RST_VAL;
            dout <= RST_VAL;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule : sfe_sync
`default_nettype wire

// >>> sfe_flash.sv
`timescale 1ns/1ps
`default_nettype none
module sfe_flash (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Link
    sfe_link_if.flash link,
    // Status bits from the neighbouring blocks
    input wire logic [2:0] protect_bits,
    input wire logic protect_complement,
    input wire logic security_lock_bit,
    // Erase reporting
    output logic write_in_progress,
    output logic write_enable_latch,
    output logic erase_start,
    output logic [1:0] erase_kind,
    output logic [23:0] erase_base,
    output logic erase_done
);
    logic cs_s, sclk_s, si_s, sclk_d, cs_d;
    logic [7:0] nbits;
    logic [7:0] opcode;
    logic [23:0] addr;
    logic [127:0] shreg;
    logic out_act;
    logic so_r;
    logic [31:0] busy_cnt;
    logic [31:0] next_cnt;
    logic [23:0] base;
    logic [23:0] last;
    logic [1:0] kind;
    logic ok, prot;
    logic [2:0] bp_rank;
    logic [18:0] prot_lo;
    logic [7:0] status;

    // Select idles high, so its copy resets high too
    sfe_sync #(.RST_VAL(1'b1)) u_cs (.clock(clock), .rst_n(rst_n), .din(link.cs_n),
        .dout(cs_s));
    sfe_sync u_ck (.clock(clock), .rst_n(rst_n), .din(link.sclk), .dout(sclk_s));
    sfe_sync u_si (.clock(clock), .rst_n(rst_n), .din(link.si), .dout(si_s));

    // Edge detect on synchronised copies
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sclk_d <= 1'b0;
            cs_d <= 1'b1;
        end else begin
            sclk_d <= sclk_s;
            cs_d <= cs_s;
        end
    end
    wire rise = sclk_s & ~sclk_d & ~cs_s;
    wire fall = ~sclk_s & sclk_d & ~cs_s;
    wire cs_up = cs_s & ~cs_d;

    assign status = {protect_complement, security_lock_bit, 1'b0, protect_bits,
                     write_enable_latch, write_in_progress};

    // Input shifter: opcode then address bytes, MSB first
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            nbits <= 8'h00;
            opcode <= 8'h00;
            addr <= 24'h000000;
        end else if (cs_s) begin
            nbits <= 8'h00;
        end else if (rise) begin
            if (nbits != 8'hff)
                nbits <= nbits + 8'h01;
            if (nbits < sfe_pkg::BITS_OP)
                opcode <= {opcode[6:0], si_s};
            else if (nbits < sfe_pkg::BITS_ADDR)
                addr <= {addr[22:0], si_s};
        end
    end

    // Protected region: top 1/2^(7-bp) of the array, complement flips to lower
    assign bp_rank = protect_bits;
    always_comb begin
        prot_lo = '1;
        if (bp_rank != sfe_pkg::BP_NONE)
            prot_lo = ~(prot_lo >> (3'd7 - bp_rank));
    end

    // Erase decode at select rise; last address catches a partial overlap
    always_comb begin
        ok = 1'b0;
        kind = 2'd0;
        base = sfe_pkg::ADDR_ZERO;
        last = sfe_pkg::ADDR_ZERO;
        prot = 1'b0;
        next_cnt = 32'd0;
        if (nbits == sfe_pkg::BITS_ADDR) begin
            case (opcode)
                sfe_pkg::OP_SECTOR_ERASE: begin
                    ok = 1'b1;
                    base = {addr[23:sfe_pkg::SECTOR_BITS], 12'h000};
                    last = {addr[23:sfe_pkg::SECTOR_BITS], 12'hfff};
                    next_cnt = sfe_pkg::SECTOR_CYC;
                end
                sfe_pkg::OP_HALF_BLOCK: begin
                    ok = 1'b1;
                    kind = 2'd1;
                    base = {addr[23:sfe_pkg::HALF_BITS], 15'h0000};
                    last = {addr[23:sfe_pkg::HALF_BITS], 15'h7fff};
                    next_cnt = sfe_pkg::HALF_CYC;
                end
                sfe_pkg::OP_FULL_BLOCK: begin
                    ok = 1'b1;
                    kind = 2'd2;
                    base = {addr[23:sfe_pkg::FULL_BITS], 16'h0000};
                    last = {addr[23:sfe_pkg::FULL_BITS], 16'hffff};
                    next_cnt = sfe_pkg::FULL_CYC;
                end
                sfe_pkg::OP_ERSEC: begin
                    ok = ((addr & sfe_pkg::SEC_ADDR_MASK) == sfe_pkg::ADDR_ZERO)
                         & ~security_lock_bit;
                    kind = 2'd3;
                    next_cnt = sfe_pkg::SECTOR_CYC;
                end
                default: ok = 1'b0;
            endcase
            // Region check; security area lies outside the protect map
            if (ok && kind != 2'd3 && protect_bits != sfe_pkg::BP_NONE) begin
                if (protect_complement)
                    prot = base[18:0] < prot_lo;
                else
                    prot = last[18:0] >= prot_lo;
            end
        end else if (nbits == sfe_pkg::BITS_OP &&
                     (opcode == sfe_pkg::OP_CE1 || opcode == sfe_pkg::OP_CE2)) begin
            ok = (protect_bits == sfe_pkg::BP_NONE && !protect_complement) ||
                 (protect_bits[2:1] == sfe_pkg::BP_UPPER_ALL && protect_complement);
            kind = 2'd0;
            next_cnt = sfe_pkg::CE_CYC;
        end
    end
    wire go = cs_up & ok & ~prot & write_enable_latch & ~write_in_progress;

    // Busy timer and flags
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            busy_cnt <= 32'd0;
            write_in_progress <= 1'b0;
            erase_done <= 1'b0;
        end else begin
            erase_done <= 1'b0;
            if (go) begin
                busy_cnt <= next_cnt;
                write_in_progress <= 1'b1;
            end else if (write_in_progress) begin
                if (busy_cnt == 32'd1) begin
                    write_in_progress <= 1'b0;
                    erase_done <= 1'b1;
                end
                busy_cnt <= busy_cnt - 32'd1;
            end
        end
    end

    // Write enable latch: set by 06H, cleared when an erase starts
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n)
            write_enable_latch <= 1'b0;
        else if (go)
            write_enable_latch <= 1'b0;
        else if (cs_up && nbits == sfe_pkg::BITS_OP && opcode == sfe_pkg::OP_WRITE_ENABLE &&
                 !write_in_progress)
            write_enable_latch <= 1'b1;
    end

    // Erase report
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            erase_start <= 1'b0;
            erase_kind <= 2'd0;
            erase_base <= 24'h000000;
        end else begin
            erase_start <= go;
            if (go) begin
                erase_kind <= kind;
                erase_base <= base;
            end
        end
    end

    // Output shifter, loaded when the opcode or preamble completes
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            shreg <= 128'h0;
            out_act <= 1'b0;
            so_r <= 1'b0;
        end else if (cs_s) begin
            out_act <= 1'b0;
            so_r <= 1'b0;
        end else if (rise && nbits == sfe_pkg::BITS_OP - 8'h01) begin
            // Opcode bits are complete after this edge
            if ({opcode[6:0], si_s} == sfe_pkg::OP_RDSR) begin
                shreg <= {status, 120'h0};
                out_act <= 1'b1;
            end else if ({opcode[6:0], si_s} == sfe_pkg::OP_IDENT_READ &&
                         !write_in_progress) begin
                shreg <= {sfe_pkg::MAKER_ID, sfe_pkg::MEM_TYPE, sfe_pkg::CAPACITY,
                          104'h0};
                out_act <= 1'b1;
            end
        end else if (rise && nbits == sfe_pkg::BITS_ADDR - 8'h01 &&
                     opcode == sfe_pkg::OP_MAKER_DEVICE_ID && !write_in_progress &&
                     {addr[22:0], si_s} == sfe_pkg::ADDR_ZERO) begin
            shreg <= {sfe_pkg::MAKER_ID, sfe_pkg::DEVICE_ID, 112'h0};
            out_act <= 1'b1;
        end else if (rise && nbits == sfe_pkg::BITS_DUMMY - 8'h01 &&
                     opcode == sfe_pkg::OP_UID && !write_in_progress &&
                     addr == sfe_pkg::ADDR_ZERO) begin
            shreg <= sfe_pkg::UNIQUE_ID;
            out_act <= 1'b1;
        end else if (fall && out_act) begin
            // Status sampled afresh at every byte, so a poll sees busy drop
            if (opcode == sfe_pkg::OP_RDSR && nbits[2:0] == 3'h0) begin
                so_r <= status[7];
                shreg <= {status[6:0], 121'h0};
            end else begin
                so_r <= shreg[127];
                shreg <= {shreg[126:0], 1'b0};
            end
        end
    end

    assign link.so = so_r;
    assign link.so_oe = out_act;
endmodule : sfe_flash
`default_nettype wire

// >>> sfe_host.sv
`timescale 1ns/1ps
`default_nettype none
module sfe_host (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Link
    sfe_link_if.host link,
    // Command request
    input wire logic cmd_valid,
    input wire sfe_pkg::sfe_cmd_e cmd_kind,
    input wire logic [7:0] cmd_opcode,
    input wire logic [23:0] cmd_addr,
    input wire logic [7:0] cmd_rd_bits,
    output logic cmd_ready,
    // Answer
    output logic [127:0] rd_data,
    output logic rd_valid
);
    typedef enum logic [1:0] {
        SFE_IDLE = 2'b00,
        SFE_SHIFT = 2'b01,
        SFE_END = 2'b10
    } sfe_hst_e;
    sfe_hst_e state;
    logic [7:0] div;
    logic [7:0] total;
    logic [7:0] cnt;
    logic [31:0] tx;
    logic so_s;
    logic sclk_r, cs_r;
    sfe_sync u_so (.clock(clock), .rst_n(rst_n), .din(link.so), .dout(so_s));

    assign cmd_ready = (state == SFE_IDLE);
    // One transfer per select; select kept low until last bit
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state <= SFE_IDLE;
            div <= 8'h00;
            cnt <= 8'h00;
            total <= 8'h00;
            tx <= 32'h0;
            sclk_r <= 1'b0;
            cs_r <= 1'b1;
            rd_data <= 128'h0;
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= 1'b0;
            case (state)
                SFE_IDLE: begin
                    if (cmd_valid) begin
                        cs_r <= 1'b0;
                        cnt <= 8'h00;
                        div <= 8'h00;
                        tx <= {cmd_opcode, cmd_addr};
                        rd_data <= 128'h0;
                        // No power-down kind exists, so id reads are legal
                        case (cmd_kind)
                            sfe_pkg::SFE_CMD_ERASE: total <= sfe_pkg::BITS_ADDR;
                            sfe_pkg::SFE_CMD_READ, sfe_pkg::SFE_CMD_RDSR: total <= cmd_rd_bits;
                            default: total <= sfe_pkg::BITS_OP;
                        endcase
                        state <= SFE_SHIFT;
                    end
                end
                SFE_SHIFT: begin
                    div <= div + 8'h01;
                    if (div == sfe_pkg::HALF_PERIOD) begin
                        div <= 8'h00;
                        sclk_r <= ~sclk_r;
                        if (sclk_r) begin
                            // Falling edge: next bit out
                            tx <= {tx[30:0], 1'b0};
                            if (cnt == total)
                                state <= SFE_END;
                        end else begin
                            rd_data <= {rd_data[126:0], so_s};
                            cnt <= cnt + 8'h01;
                        end
                    end
                end
                SFE_END: begin
                    cs_r <= 1'b1;
                    rd_valid <= 1'b1;
                    state <= SFE_IDLE;
                end
                default: state <= SFE_IDLE;
            endcase
        end
    end
    assign link.cs_n = cs_r;
    assign link.sclk = sclk_r;
    assign link.si = tx[31];
endmodule : sfe_host
`default_nettype wire

// >>> sfe_checker.sv
`timescale 1ns/1ps
`default_nettype none
module sfe_checker (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Link
    input wire logic cs_n,
    input wire logic so_oe,
    // Flash status
    input wire logic security_lock_bit,
    input wire logic write_in_progress,
    input wire logic write_enable_latch,
    input wire logic erase_start,
    input wire logic [1:0] erase_kind,
    input wire logic [23:0] erase_base,
    input wire logic erase_done
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    // End of a self-timed cycle: busy and latch both gone
    sequence s_cycle_end;
        ##[0:2] (!write_in_progress && !write_enable_latch);
    endsequence

    // Start only after release of select and never over a running cycle
    chk_start_idle: assert property (erase_start |-> cs_n && !$past(write_in_progress))
        else $error("erase start while selected or busy");
    // Latch was set before the select was released
    chk_start_latch: assert property (erase_start |-> $past(write_enable_latch, 5))
        else $error("erase start without write enable");
    // Busy flag raised and kept after a start
    chk_busy_held: assert property (erase_start |=> write_in_progress [*4])
        else $error("busy flag not held after start");
    chk_done_clear: assert property (erase_done |-> s_cycle_end)
        else $error("busy or latch left after done");
    // Busy ends only beside the done pulse
    chk_fall_done: assert property ($fell(write_in_progress) |->
        erase_done || $past(erase_done) || $past(erase_done, 2))
        else $error("busy fell without done");
    // Target must not move while a cycle runs, a late id read included
    chk_target_hold: assert property (write_in_progress && $past(write_in_progress, 2) |->
        $stable(erase_base) && $stable(erase_kind))
        else $error("erase target changed while busy");
    chk_lock_refuse: assert property (erase_start |-> !(erase_kind == 2'h3 && security_lock_bit))
        else $error("security erase despite lock");
    chk_wel_idle: assert property ($rose(write_enable_latch) |-> !write_in_progress)
        else $error("latch set while busy");
    // Output driver off once deselected; six cycles cover the synchroniser
    chk_so_quiet: assert property (cs_n && $past(cs_n, 6) |-> !so_oe)
        else $error("output driven while deselected");
endmodule : sfe_checker
`default_nettype wire

// >>> sfe_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define SFE_CHK(g, e) begin \
    n_tests++; \
    if ((g) !== (e)) begin \
        n_errors++; \
        $display("unexpected at %0t: got %0h expected %0h", $time, (g), (e)); \
    end \
end
module sfe_tb_top;
    typedef struct {
        logic chip;
        logic [7:0] op;
        logic [23:0] a;
        logic [2:0] bp;
        logic [3:0] f;
        logic [1:0] ek;
        logic [23:0] eb;
    } sfe_row_s;
    // Flags f: complement, lock, write enable first, start expected
    sfe_row_s rows [14] = '{
        '{1'b0, 8'h20, 24'h001234, 3'h0, 4'h3, 2'h0, 24'h001000},
        '{1'b0, 8'h20, 24'h07f123, 3'h1, 4'h2, 2'h0, 24'h000000},
        '{1'b0, 8'h52, 24'h00a123, 3'h0, 4'h3, 2'h1, 24'h008000},
        '{1'b0, 8'hd8, 24'h01abcd, 3'h0, 4'h3, 2'h2, 24'h010000},
        '{1'b0, 8'hd8, 24'h07ffff, 3'h2, 4'h2, 2'h0, 24'h000000},
        '{1'b1, 8'h60, 24'h000000, 3'h0, 4'h3, 2'h0, 24'h000000},
        '{1'b1, 8'hc7, 24'h000000, 3'h6, 4'hb, 2'h0, 24'h000000},
        '{1'b1, 8'h60, 24'h000000, 3'h1, 4'h2, 2'h0, 24'h000000},
        '{1'b0, 8'h44, 24'h000000, 3'h0, 4'h3, 2'h3, 24'h000000},
        '{1'b0, 8'h44, 24'h000000, 3'h0, 4'h6, 2'h0, 24'h000000},
        '{1'b0, 8'h44, 24'h001000, 3'h0, 4'h2, 2'h0, 24'h000000},
        '{1'b1, 8'h20, 24'h001234, 3'h0, 4'h2, 2'h0, 24'h000000},
        '{1'b0, 8'h60, 24'h000000, 3'h0, 4'h2, 2'h0, 24'h000000},
        '{1'b0, 8'h20, 24'h001234, 3'h0, 4'h0, 2'h0, 24'h000000}
    };
    logic clock;
    logic rst_n = 1'b0;
    logic cmd_valid = 1'b0;
    sfe_pkg::sfe_cmd_e cmd_kind = sfe_pkg::SFE_CMD_WRITE_ENABLE;
    logic [7:0] cmd_opcode = 8'h00;
    logic [23:0] cmd_addr = 24'h000000;
    logic [7:0] cmd_rd_bits = 8'h00;
    logic [2:0] protect_bits = 3'h0;
    logic protect_complement = 1'b0;
    logic security_lock_bit = 1'b0;
    logic cmd_ready, rd_valid, busy, latch, erase_start, erase_done;
    logic [127:0] rd_data, got;
    logic [1:0] erase_kind, s_kind;
    logic [23:0] erase_base, s_base;
    int n_errors = 0;
    int n_tests = 0;
    int n_start = 0;
    int n_oe = 0;
    int n_done = 0;
    int n0, i;

    sfe_link_if link_if ();
    sfe_host sfe_host_inst (.clock(clock), .rst_n(rst_n), .link(link_if),
        .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_opcode(cmd_opcode),
        .cmd_addr(cmd_addr), .cmd_rd_bits(cmd_rd_bits), .cmd_ready(cmd_ready),
        .rd_data(rd_data), .rd_valid(rd_valid));
    sfe_flash sfe_flash_inst (.clock(clock), .rst_n(rst_n), .link(link_if),
        .protect_bits(protect_bits), .protect_complement(protect_complement),
        .security_lock_bit(security_lock_bit), .write_in_progress(busy),
        .write_enable_latch(latch), .erase_start(erase_start), .erase_kind(erase_kind),
        .erase_base(erase_base), .erase_done(erase_done));
    sfe_checker sfe_checker_inst (.clock(clock), .rst_n(rst_n), .cs_n(link_if.cs_n),
        .so_oe(link_if.so_oe), .security_lock_bit(security_lock_bit),
        .write_in_progress(busy), .write_enable_latch(latch), .erase_start(erase_start),
        .erase_kind(erase_kind), .erase_base(erase_base), .erase_done(erase_done));

    // 200 MHz system clock
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    // Capture read answers, erase starts and output-enable activity
    always @(posedge clock) begin
        if (rd_valid) got <= rd_data;
        if (link_if.so_oe) n_oe <= n_oe + 1;
        if (erase_done) n_done <= n_done + 1;
        if (erase_start) begin
            n_start <= n_start + 1;
            s_kind <= erase_kind;
            s_base <= erase_base;
        end
    end

    task automatic end_of_test();
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_of_test

    // Bounded wait; a hung host ends the run as a failure
    task automatic wait_ready();
        int k;
        for (k = 0; k < 8000 && cmd_ready !== 1'b1; k++) @(negedge clock);
        if (cmd_ready !== 1'b1) begin
            n_errors++;
            end_of_test();
        end
    endtask : wait_ready

    // Valid held until the edge that sees ready, then released
    task automatic send(input sfe_pkg::sfe_cmd_e k, input logic [7:0] op,
                        input logic [23:0] a, input logic [7:0] nb);
        @(negedge clock);
        cmd_kind = k;
        cmd_opcode = op;
        cmd_addr = a;
        cmd_rd_bits = nb;
        cmd_valid = 1'b1;
        wait_ready();
        @(negedge clock);
        cmd_valid = 1'b0;
        wait_ready();
        repeat (8) @(negedge clock);
    endtask : send

    task automatic do_reset();
        @(negedge clock);
        rst_n = 1'b0;
        repeat (10) @(negedge clock);
        rst_n = 1'b1;
    endtask : do_reset

    initial begin
        do_reset();
        `SFE_CHK({busy, latch, erase_start, erase_done}, 4'h0)
        // Each row runs from reset, so accepted erases are cut short mid-cycle
        foreach (rows[r]) begin
            do_reset();
            protect_bits = rows[r].bp;
            {protect_complement, security_lock_bit} = rows[r].f[3:2];
            if (rows[r].f[1]) begin
                send(sfe_pkg::SFE_CMD_WRITE_ENABLE, 8'h06, 24'h000000, 8'h00);
                `SFE_CHK(latch, 1'b1)
            end
            n0 = n_start;
            send(rows[r].chip ? sfe_pkg::SFE_CMD_CHIP : sfe_pkg::SFE_CMD_ERASE,
                 rows[r].op, rows[r].a, 8'h00);
            `SFE_CHK(n_start != n0, rows[r].f[0])
            if (rows[r].f[0]) begin
                `SFE_CHK({s_kind, s_base}, {rows[r].ek, rows[r].eb})
                `SFE_CHK(busy, 1'b1)
            end
        end
        // Full sector cycle with status, enable and id reads while busy
        do_reset();
        send(sfe_pkg::SFE_CMD_WRITE_ENABLE, 8'h06, 24'h000000, 8'h00);
        send(sfe_pkg::SFE_CMD_ERASE, 8'h20, 24'h003000, 8'h00);
        send(sfe_pkg::SFE_CMD_RDSR, 8'h05, 24'h000000, 8'h18);
        // Two status bytes, busy only: nothing protected, latch already gone
        `SFE_CHK(got[15:0], 16'h0101)
        send(sfe_pkg::SFE_CMD_WRITE_ENABLE, 8'h06, 24'h000000, 8'h00);
        `SFE_CHK(latch, 1'b0)
        n0 = n_oe;
        send(sfe_pkg::SFE_CMD_READ, 8'h9f, 24'h000000, 8'h20);
        `SFE_CHK(n_oe == n0, 1'b1)
        `SFE_CHK(busy, 1'b1)
        for (i = 0; i < sfe_pkg::SECTOR_CYC + 1000 && busy !== 1'b0; i++) @(negedge clock);
        `SFE_CHK(busy, 1'b0)
        if (busy !== 1'b0) end_of_test();
        `SFE_CHK(latch, 1'b0)
        `SFE_CHK(i > sfe_pkg::SECTOR_CYC / 2, 1'b1)
        // Identification reads in standby, one cut short by the host
        send(sfe_pkg::SFE_CMD_READ, 8'h90, 24'h000000, 8'h30);
        `SFE_CHK(got[15:0], {sfe_pkg::MAKER_ID, sfe_pkg::DEVICE_ID})
        `SFE_CHK(n_done, 1)
        send(sfe_pkg::SFE_CMD_READ, 8'h9f, 24'h000000, 8'h20);
        `SFE_CHK(got[23:0], {sfe_pkg::MAKER_ID, sfe_pkg::MEM_TYPE, sfe_pkg::CAPACITY})
        send(sfe_pkg::SFE_CMD_READ, 8'h9f, 24'h000000, 8'h10);
        `SFE_CHK(got[7:0], sfe_pkg::MAKER_ID)
        send(sfe_pkg::SFE_CMD_READ, 8'h4b, 24'h000000, 8'ha8);
        `SFE_CHK(got, sfe_pkg::UNIQUE_ID)
        end_of_test();
    end
endmodule : sfe_tb_top
`default_nettype wire
